// [hdl/acsm_pkg.sv]
// constants, field layout and decode helpers of the angle sensor
// configuration memory; shared by the top and both submodules
package acsm_pkg;

  typedef logic [3:0] acsm_addr_t;
  typedef logic [11:0] acsm_word_t;
  typedef logic [6:0][11:0] acsm_bank_t;

  // ==========================================================
  // word addresses
  localparam acsm_addr_t ADDR_RESV_LAST = 4'h3;
  localparam acsm_addr_t ADDR_USER_ID_1 = 4'h4;
  localparam acsm_addr_t ADDR_USER_ID_2 = 4'h5;
  localparam acsm_addr_t ADDR_ZERO_POINT = 4'h6;
  localparam acsm_addr_t ADDR_INCR_CFG = 4'h7;
  localparam acsm_addr_t ADDR_LOCK_CFG = 4'h8;
  localparam acsm_addr_t ADDR_DIAG_DIS = 4'h9;
  localparam acsm_addr_t ADDR_COMMUT_CFG = 4'ha;
  localparam int NUM_WORDS = 7;

  // ==========================================================
  // reset values of the stored words
  localparam acsm_word_t RST_USER_ID = 12'h000;
  localparam acsm_word_t RST_ZERO_POINT = 12'h000;
  localparam acsm_word_t RST_INCR_CFG = 12'h0a0;
  localparam acsm_word_t RST_LOCK_CFG = 12'h003;
  localparam acsm_word_t RST_DIAG_DIS = 12'h000;
  localparam acsm_word_t RST_COMMUT_CFG = 12'h052;

  // ==========================================================
  // field positions
  localparam int DIR_BIT = 9;
  localparam int ZFORM_BIT = 8;
  localparam int QOE_BIT = 7;
  localparam int HYS_LSB = 4;
  localparam int RES_LSB = 0;
  localparam int FLUX_DIS_BIT = 1;
  localparam int TRACK_DIS_BIT = 0;
  localparam logic [1:0] LOCK_OPEN = 2'h3;
  localparam logic [11:0] HALF_TURN = 12'h800;

  // hysteresis code to counts; -1 means hysteresis disabled
  function automatic logic signed [2:0] hys_counts(input logic [2:0] code);
    unique case (code)
      3'h0: hys_counts = -3'sd1;
      3'h1: hys_counts = 3'sd0;
      3'h3: hys_counts = 3'sd2;
      3'h4: hys_counts = 3'sd3;
      default: hys_counts = 3'sd1;
    endcase
  endfunction : hys_counts

  // resolution code to pulses per revolution
  function automatic logic [10:0] res_ppr(input logic [3:0] code);
    unique case (code)
      4'h0: res_ppr = 11'd1024;
      4'h1: res_ppr = 11'd512;
      4'h2: res_ppr = 11'd256;
      4'h3: res_ppr = 11'd128;
      4'h4: res_ppr = 11'd1000;
      4'h5: res_ppr = 11'd900;
      4'h6: res_ppr = 11'd800;
      4'h7: res_ppr = 11'd700;
      4'h8: res_ppr = 11'd600;
      4'h9: res_ppr = 11'd500;
      4'ha: res_ppr = 11'd400;
      4'hb: res_ppr = 11'd360;
      4'hc: res_ppr = 11'd300;
      4'hd: res_ppr = 11'd200;
      4'he: res_ppr = 11'd100;
      default: res_ppr = 11'd50;
    endcase
  endfunction : res_ppr

endpackage : acsm_pkg

// [hdl/acsm_cfg_if.sv]
// working incremental configuration from the top to the quadrature
// generator, and the generator's registered outputs back
`timescale 1ns/10ps
interface acsm_cfg_if;
  logic dir;
  logic zform;
  logic q_oe;
  logic [2:0] hys;
  logic [3:0] res;
  logic [11:0] zp;
  logic [11:0] angle;
  logic qa;
  logic qb;
  logic qz;
  logic qen;
  modport ctrl (output dir, zform, q_oe, hys, res, zp, angle,
                input qa, qb, qz, qen);
  modport gen (input dir, zform, q_oe, hys, res, zp, angle,
               output qa, qb, qz, qen);
endinterface : acsm_cfg_if

// [hdl/acsm_nvm_array.sv]
// non-volatile word store for addresses 0x04..0x0a
// assumes the caller has already checked mode, range and lock
`timescale 1ns/10ps
module acsm_nvm_array
  import acsm_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire acsm_pkg::acsm_word_t wr_data,
  output acsm_pkg::acsm_bank_t words
);
  import acsm_pkg::*;

  typedef struct packed {
    acsm_bank_t mem;
  } acsm_nvm_s;

  acsm_nvm_s st;
  acsm_nvm_s next_st;

  // ==========================================================
  // storage
  always_comb
  begin
    next_st = st;
    if (wr_en)
    begin
      next_st.mem[wr_idx] = wr_data;
    end
  end

  // reset stands in for a blank part: defaults of every word
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st.mem[0] <= RST_USER_ID;
      st.mem[1] <= RST_USER_ID;
      st.mem[2] <= RST_ZERO_POINT;
      st.mem[3] <= RST_INCR_CFG;
      st.mem[4] <= RST_LOCK_CFG;
      st.mem[5] <= RST_DIAG_DIS;
      st.mem[6] <= RST_COMMUT_CFG;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign words = st.mem;

endmodule : acsm_nvm_array

// [hdl/acsm_quad_gen.sv]
// incremental a/b/z generator with direction, zero point,
// hysteresis and resolution; angle input is synchronous
`timescale 1ns/10ps
module acsm_quad_gen
  import acsm_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  acsm_cfg_if.gen cfg
);
  import acsm_pkg::*;

  typedef struct packed {
    logic [11:0] pos;
    logic [11:0] last_raw;
    logic last_up;
    logic move_up;
    logic qa;
    logic qb;
    logic qz;
    logic qen;
  } acsm_quad_s;

  acsm_quad_s st;
  acsm_quad_s next_st;
  logic [11:0] raw;
  logic [11:0] diff;
  logic [11:0] step;
  logic step_up;
  logic signed [2:0] hys_n;
  logic [23:0] scaled;
  logic [11:0] abz;

  always_comb
  begin
    next_st = st;
    // direction then zero point ahead of everything else
    raw = cfg.dir ? 12'(12'h000 - cfg.angle) : cfg.angle;
    raw = 12'(raw - cfg.zp);
    hys_n = hys_counts(cfg.hys);
    diff = 12'(raw - st.pos);
    step = 12'(raw - st.last_raw);
    step_up = ~diff[11];
    next_st.last_raw = raw;
    if (step != 12'h000)
    begin
      next_st.last_up = ~step[11];
    end
    if (hys_n < 0)
    begin
      next_st.pos = raw;
    end
    else if (hys_n == 3'sd0)
    begin
      // two steps the same way before the output moves
      if (step != 12'h000 && ~step[11] == st.last_up)
      begin
        next_st.pos = raw;
      end
    end
    else if (diff != 12'h000)
    begin
      // reversal must exceed n counts; same way follows at once
      if (step_up == st.move_up ||
          (step_up ? diff : 12'(12'h000 - diff)) >
            12'(hys_n))
      begin
        next_st.pos = raw;
        next_st.move_up = step_up;
      end
    end
    // full product needs 24 bits; dividing by 4096 keeps the top 12
    scaled = 24'(st.pos * {res_ppr(cfg.res), 2'b00});
    abz = scaled[23:12];
    next_st.qa = abz[1];
    next_st.qb = abz[1] ^ abz[0];
    next_st.qz = cfg.zform ? (st.pos < HALF_TURN)
                           : (abz == 12'h000);
    next_st.qen = cfg.q_oe;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign cfg.qa = st.qa;
  assign cfg.qb = st.qb;
  assign cfg.qz = st.qz;
  assign cfg.qen = st.qen;

endmodule : acsm_quad_gen

// [hdl/acsm_top.sv]
// angle sensor configuration memory: word access port, lock,
// working copies of the stored words and the incremental outputs
// assumes a host controller drives the word port synchronously and
// presents the tracked 12-bit angle on angle_in every cycle
//
// Function
// - words 0..3 and above 0x0a refused; others only in user mode
// - after locking every write is rejected
// - copy words to working set at power-up, normal entry
// - two 12-bit id words, default zero
// - zero point offsets angle, 360/4096 per count
// - zero point feeds quadrature and commutation
// - incremental word bit layout fixed
// - direction bit selects counting sense
// - z normal form marks zero position
// - z switch form high below half turn
// - output enable low floats a, b, z; here only quad_oe goes low, a, b, z keep driving
// - hysteresis code decode table
// - disabled hysteresis follows angle directly
// - zero-count hysteresis needs two steps same way
// - commutation settings kept at word 0x0a
// - lock field other than 3 locks memory
// - lock never clears, contents frozen
// - diagnosis disable bits for flux and tracking
// - resolution code to pulses per revolution
`timescale 1ns/10ps
module acsm_top
  import acsm_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic user_mode,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire acsm_pkg::acsm_addr_t acc_addr,
  input wire acsm_pkg::acsm_word_t acc_wdata,
  input wire logic [11:0] angle_in,
  output acsm_pkg::acsm_word_t acc_rdata,
  output logic acc_ack,
  output logic acc_err,
  output logic mem_locked,
  output logic quad_a,
  output logic quad_b,
  output logic quad_z,
  output logic quad_oe,
  output logic [11:0] commut_angle,
  output acsm_pkg::acsm_word_t commut_config,
  output logic flux_check_en,
  output logic track_check_en
);
  import acsm_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    acsm_word_t work_zp;
    acsm_word_t work_incr;
    acsm_word_t work_lock;
    acsm_word_t work_diag;
    acsm_word_t work_commut;
    logic mode_user;
    logic load_pend;
    acsm_word_t rdata;
    logic ack;
    logic err;
    logic locked;
    logic [11:0] commut_ang;
    logic flux_en;
    logic track_en;
  } acsm_top_s;

  acsm_top_s st;
  acsm_top_s next_st;
  acsm_bank_t words;
  logic wr_en;
  logic [2:0] wr_idx;
  logic in_map;
  logic permitted;
  logic store_locked;
  logic [11:0] dir_angle;

  acsm_cfg_if cfg_bus ();

  // ==========================================================
  // word store
  acsm_nvm_array u_nvm (
    .core_clk (core_clk),
    .sys_rst (sys_rst),
    .wr_en (wr_en),
    .wr_idx (wr_idx),
    .wr_data (acc_wdata),
    .words (words)
  );

  // ==========================================================
  // incremental output generator
  acsm_quad_gen u_quad (
    .core_clk (core_clk),
    .sys_rst (sys_rst),
    .cfg (cfg_bus.gen)
  );

  // working copy drives the outputs, never the stored word, so a
  // fresh write stays inactive until the next load
  assign cfg_bus.dir = st.work_incr[DIR_BIT];
  assign cfg_bus.zform = st.work_incr[ZFORM_BIT];
  assign cfg_bus.q_oe = st.work_incr[QOE_BIT];
  assign cfg_bus.hys = st.work_incr[HYS_LSB +: 3];
  assign cfg_bus.res = st.work_incr[RES_LSB +: 4];
  assign cfg_bus.zp = st.work_zp;
  assign cfg_bus.angle = angle_in;

  // ==========================================================
  // access decode
  always_comb
  begin
    // lock is judged from the stored word so it bites at once
    store_locked = words[ADDR_LOCK_CFG - ADDR_USER_ID_1][1:0]
                   != LOCK_OPEN;
    in_map = acc_addr > ADDR_RESV_LAST &&
             acc_addr <= ADDR_COMMUT_CFG;
    permitted = in_map && user_mode;
    wr_idx = 3'(acc_addr - ADDR_USER_ID_1);
    wr_en = acc_req && acc_write && permitted &&
            !store_locked;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.mode_user = user_mode;
    next_st.locked = store_locked;
    if (acc_req)
    begin
      next_st.ack = 1'b1;
      next_st.err = !permitted || (acc_write && store_locked);
      if (!acc_write && permitted)
      begin
        next_st.rdata = words[wr_idx];
      end
      else
      begin
        next_st.rdata = 12'h000;
      end
    end
    // power-up copy, and again on every drop out of user mode
    if (st.load_pend || (st.mode_user && !user_mode))
    begin
      next_st.load_pend = 1'b0;
      next_st.work_zp = words[ADDR_ZERO_POINT - ADDR_USER_ID_1];
      next_st.work_incr = words[ADDR_INCR_CFG - ADDR_USER_ID_1];
      next_st.work_lock = words[ADDR_LOCK_CFG - ADDR_USER_ID_1];
      next_st.work_diag = words[ADDR_DIAG_DIS - ADDR_USER_ID_1];
      next_st.work_commut =
        words[ADDR_COMMUT_CFG - ADDR_USER_ID_1];
      next_st.flux_en = !next_st.work_diag[FLUX_DIS_BIT];
      next_st.track_en = !next_st.work_diag[TRACK_DIS_BIT];
    end
    // commutation sees the same zero point as the quadrature
    dir_angle = st.work_incr[DIR_BIT] ? 12'(12'h000 - angle_in)
                                      : angle_in;
    next_st.commut_ang = 12'(dir_angle - st.work_zp);
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st.work_zp <= RST_ZERO_POINT;
      st.work_incr <= RST_INCR_CFG;
      st.work_lock <= RST_LOCK_CFG;
      st.work_diag <= RST_DIAG_DIS;
      st.work_commut <= RST_COMMUT_CFG;
      st.mode_user <= 1'b0;
      st.load_pend <= 1'b1;
      st.rdata <= 12'h000;
      st.ack <= 1'b0;
      st.err <= 1'b0;
      st.locked <= 1'b0;
      st.commut_ang <= 12'h000;
      st.flux_en <= !RST_DIAG_DIS[FLUX_DIS_BIT];
      st.track_en <= !RST_DIAG_DIS[TRACK_DIS_BIT];
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign acc_rdata = st.rdata;
  assign acc_ack = st.ack;
  assign acc_err = st.err;
  assign mem_locked = st.locked;
  assign quad_a = cfg_bus.qa;
  assign quad_b = cfg_bus.qb;
  assign quad_z = cfg_bus.qz;
  assign quad_oe = cfg_bus.qen;
  assign commut_angle = st.commut_ang;
  assign commut_config = st.work_commut;
  assign flux_check_en = st.flux_en;
  assign track_check_en = st.track_en;

endmodule : acsm_top

// [bench/acsm_host.sv]
// host controller model driving the word access port of the block
// assumes tb supplies the clock and wires the answer signals back
`timescale 1ns/10ps
module acsm_host
  import acsm_pkg::*;
(
  input wire logic core_clk,
  input wire logic acc_ack,
  input wire logic acc_err,
  input wire acsm_pkg::acsm_word_t acc_rdata,
  output logic user_mode,
  output logic acc_req,
  output logic acc_write,
  output acsm_pkg::acsm_addr_t acc_addr,
  output acsm_pkg::acsm_word_t acc_wdata
);
  import acsm_pkg::*;

  // qualifiers stay unset until the first access; the request is low
  initial
  begin
    user_mode = 1'b0;
    acc_req = 1'b0;
  end

  // ======
  // mode switch; written words other than the lock only act after a return to normal
  task automatic mode(input logic m);
    @(posedge core_clk);
    user_mode <= m;
  endtask : mode

  // one word per access, answer awaited for at most four edges
  task automatic xfer(input logic wr, input acsm_addr_t a,
                      input acsm_word_t d, output acsm_word_t q,
                      output logic e, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge core_clk);
    acc_req <= 1'b1;
    acc_write <= wr;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge core_clk);
    acc_req <= 1'b0;
    // released lines show the inverse so a stale value is never trusted
    acc_addr <= ~a;
    acc_wdata <= ~d;
    for (n = 0; n < 4 && !ok; n++)
    begin
      @(posedge core_clk);
      ok = (acc_ack === 1'b1);
    end
    q = acc_rdata;
    e = acc_err;
  endtask : xfer
endmodule : acsm_host

// [bench/acsm_top_sva.sv]
// checker for the access port and lock of the configuration memory
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
module acsm_top_chk
  import acsm_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic user_mode,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire acsm_pkg::acsm_addr_t acc_addr,
  input wire acsm_pkg::acsm_word_t acc_wdata,
  input wire acsm_pkg::acsm_word_t acc_rdata,
  input wire logic acc_ack,
  input wire logic acc_err,
  input wire logic mem_locked,
  input wire acsm_pkg::acsm_word_t commut_config,
  input wire logic flux_check_en,
  input wire logic track_check_en
);
  import acsm_pkg::*;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ======
  // access answers
  ack_follows_a:
    assert property (acc_req |=> acc_ack)
    else $error("request without acknowledge");
  ack_cause_a:
    assert property (acc_ack |-> $past(acc_req))
    else $error("acknowledge without request");
  resv_refused_a:
    assert property (acc_req && acc_addr <= ADDR_RESV_LAST
                     |=> acc_err && acc_rdata == 12'h000)
    else $error("reserved word not refused");
  mode_refused_a:
    assert property (acc_req && (acc_addr > ADDR_COMMUT_CFG || !user_mode)
                     |=> acc_err)
    else $error("access outside user map not refused");
  user_read_a:
    assert property (acc_req && !acc_write && user_mode &&
      acc_addr inside {[ADDR_USER_ID_1:ADDR_COMMUT_CFG]} |=> !acc_err)
    else $error("legal read refused");

  // ======
  // lock and deferred use of stored words
  locked_write_a:
    assert property (acc_req && acc_write && mem_locked |=> acc_err)
    else $error("write accepted while locked");
  lock_set_a:
    assert property (acc_req && acc_write && user_mode &&
      acc_addr == ADDR_LOCK_CFG && acc_wdata[1:0] != LOCK_OPEN
      |=> ##1 mem_locked)
    else $error("lock code did not lock");
  lock_sticky_a:
    assert property (mem_locked |=> mem_locked)
    else $error("lock released");
  user_hold_a:
    assert property (user_mode && $past(user_mode) |-> $stable(commut_config)
      && $stable({flux_check_en, track_check_en}))
    else $error("working copy changed in user mode");

  cover property (acc_req && acc_write && acc_addr == ADDR_LOCK_CFG);
  cover property ($fell(user_mode));
  cover property (acc_ack && acc_err);
endmodule : acsm_top_chk

bind acsm_top acsm_top_chk u_chk (.core_clk, .sys_rst, .user_mode,
  .acc_req, .acc_write, .acc_addr, .acc_wdata, .acc_rdata, .acc_ack,
  .acc_err, .mem_locked, .commut_config, .flux_check_en, .track_check_en);

// [bench/tb.sv]
// self-checking bench for the angle sensor configuration memory
// assumes the host model drives the access port and tb the angle
`timescale 1ns/10ps
module tb;
  import acsm_pkg::*;
  logic core_clk;
  logic sys_rst;
  logic [11:0] angle_in;
  logic user_mode, acc_req, acc_write, acc_ack, acc_err, mem_locked;
  logic quad_a, quad_b, quad_z, quad_oe, flux_check_en, track_check_en;
  acsm_addr_t acc_addr;
  acsm_word_t acc_wdata, acc_rdata, commut_config, q;
  logic [11:0] commut_angle, ab;
  logic e, ok;
  int err_count, total_checks, i, j, k;
  int ppr[16] = '{1024, 512, 256, 128, 1000, 900, 800, 700, 600, 500,
                  400, 360, 300, 200, 100, 50};
  int hk[8] = '{1, 1, 1, 2, 3, 1, 1, 1};
  acsm_word_t dflt[7] = '{RST_USER_ID, RST_USER_ID, RST_ZERO_POINT,
    RST_INCR_CFG, RST_LOCK_CFG, RST_DIAG_DIS, RST_COMMUT_CFG};

  assign ab = {9'h000, quad_z, quad_a, quad_b};

  acsm_host host (.core_clk(core_clk), .acc_ack(acc_ack),
    .acc_err(acc_err), .acc_rdata(acc_rdata), .user_mode(user_mode),
    .acc_req(acc_req), .acc_write(acc_write), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata));

  acsm_top DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .user_mode(user_mode), .acc_req(acc_req), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .angle_in(angle_in),
    .acc_rdata(acc_rdata), .acc_ack(acc_ack), .acc_err(acc_err),
    .mem_locked(mem_locked), .quad_a(quad_a), .quad_b(quad_b),
    .quad_z(quad_z), .quad_oe(quad_oe), .commut_angle(commut_angle),
    .commut_config(commut_config), .flux_check_en(flux_check_en),
    .track_check_en(track_check_en));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ======
  // shared tasks
  function automatic logic [11:0] zab(input int p);
    logic [11:0] v;
    v = p[11:0];
    zab = {9'h000, v == 12'h000, v[1], v[1] ^ v[0]};
  endfunction : zab

  task automatic chk(input string nm, input logic [11:0] x,
                     input logic [11:0] g);
    total_checks++;
    if (g !== x)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, x, g);
    end
  endtask : chk

  task automatic op(input logic wr, input logic [3:0] a,
                    input logic [11:0] d, input logic xe,
                    input logic [11:0] xq);
    host.xfer(wr, a, d, q, e, ok);
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("unexpected ack: expected 1, seen 0");
      finish_test();
    end
    chk("err", 12'(xe), 12'(e));
    chk("rdata", xq, q);
  endtask : op

  task automatic cfg(input logic [3:0] a, input logic [11:0] d);
    host.mode(1'b1);
    op(1'b1, a, d, 1'b0, 12'h000);
    host.mode(1'b0);
    repeat (4) @(posedge core_clk);
  endtask : cfg

  task automatic ang(input logic [11:0] v, input int n);
    @(posedge core_clk);
    angle_in <= v;
    repeat (n) @(posedge core_clk);
  endtask : ang

  task automatic do_reset;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : do_reset

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // ======
  // main sequence
  initial
  begin
    err_count = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    angle_in = 12'h000;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("oe", 12'h001, 12'(quad_oe));
    chk("commut", RST_COMMUT_CFG, commut_config);
    chk("diag", 12'h003, 12'({flux_check_en, track_check_en}));
    host.mode(1'b1);
    for (i = 4; i <= 10; i++)
      op(1'b0, i[3:0], 12'h000, 1'b0, dflt[i-4]);
    $display("test reset done");
    for (i = 0; i < 16; i++)
      if (i < 4 || i > 10)
        op(1'b0, i[3:0], 12'h000, 1'b1, 12'h000);
    op(1'b1, 4'h2, 12'h5a5, 1'b1, 12'h000);
    host.mode(1'b0);
    op(1'b0, 4'h4, 12'h000, 1'b1, 12'h000);
    op(1'b1, 4'h4, 12'hfff, 1'b1, 12'h000);
    host.mode(1'b1);
    op(1'b0, 4'h4, 12'h000, 1'b0, 12'h000);
    op(1'b1, 4'h4, 12'hfff, 1'b0, 12'h000);
    op(1'b1, 4'h5, 12'h5a5, 1'b0, 12'h000);
    op(1'b0, 4'h4, 12'h000, 1'b0, 12'hfff);
    op(1'b0, 4'h5, 12'h000, 1'b0, 12'h5a5);
    $display("test access done");
    op(1'b1, 4'h9, 12'h002, 1'b0, 12'h000);
    op(1'b1, 4'ha, 12'h07f, 1'b0, 12'h000);
    repeat (3) @(posedge core_clk);
    chk("diag", 12'h003, 12'({flux_check_en, track_check_en}));
    host.mode(1'b0);
    repeat (4) @(posedge core_clk);
    chk("diag", 12'h001, 12'({flux_check_en, track_check_en}));
    chk("commut", 12'h07f, commut_config);
    $display("test deferred done");
    ang(12'h200, 2);
    cfg(4'h6, 12'h100);
    chk("angle", 12'h100, commut_angle);
    cfg(4'h7, 12'h280);
    chk("angle", 12'hd00, commut_angle);
    cfg(4'h7, 12'h080);
    ang(12'h100, 4);
    chk("zab", 12'h004, ab);
    ang(12'h101, 4);
    chk("zab", 12'h001, ab);
    cfg(4'h7, 12'h180);
    chk("zab", 12'h005, ab);
    ang(12'h900, 4);
    chk("zab", 12'h000, ab);
    cfg(4'h7, 12'h000);
    chk("oe", 12'h000, 12'(quad_oe));
    cfg(4'h6, 12'h000);
    $display("test outputs done");
    ang(12'h123, 1);
    for (i = 0; i < 16; i++)
    begin
      cfg(4'h7, 12'h080 | 12'(i));
      chk("zab", zab((12'h123 * ppr[i] * 4) >> 12), ab);
    end
    $display("test resolution done");
    for (i = 0; i < 8; i++)
    begin
      cfg(4'h7, 12'h080 | 12'(i << 4));
      k = hk[i];
      for (j = 0; j <= 8; j++) ang(12'h200 + 12'(j), 0);
      ang(12'h208, 4);
      chk("zab", zab(12'h208), ab);
      ang(12'h208 - 12'(k), 4);
      chk("zab", zab(i == 0 ? 12'h207 : 12'h208), ab);
      ang(12'h207 - 12'(k), 4);
      chk("zab", zab(12'h207 - 12'(k)), ab);
    end
    $display("test hysteresis done");
    for (i = 0; i < 3; i++)
    begin
      do_reset();
      host.mode(1'b1);
      op(1'b1, 4'h8, 12'(i), 1'b0, 12'h000);
      @(posedge core_clk);
      chk("locked", 12'h001, 12'(mem_locked));
      op(1'b1, 4'h4, 12'habc, 1'b1, 12'h000);
      op(1'b1, 4'h8, 12'h003, 1'b1, 12'h000);
      op(1'b0, 4'h4, 12'h000, 1'b0, 12'h000);
      op(1'b0, 4'h8, 12'h000, 1'b0, 12'(i));
      chk("locked", 12'h001, 12'(mem_locked));
    end
    $display("test lock done");
    finish_test();
  end
endmodule : tb
